// [rtl/icc_pkg.sv]
// Package for the input capture channel: mode codes, widths and constants.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
// Functional notes
// R1: On a capture event latch the selected 16 or 32 bit time base.
// R2: Falling-edge mode captures on every falling transition of the input.
// R3: Rising-edge mode captures on every rising transition of the input.
// R4: Both-edges mode captures on every rising and falling transition.
// R5: Specified-first mode captures every edge after a chosen first polarity appears.
// R6: Divide-by-four mode captures on every fourth rising edge.
// R7: Divide-by-sixteen mode captures on every sixteenth rising edge.
// R8: Time base is first timer, second timer, or both joined as 32 bits.
// R9: A qualifying pin event raises a wake request for sleep and idle.
// R10: The channel raises an interrupt request on capture events.
// R11: Captured values wait in a four-entry first-in first-out buffer.
// R12: Interrupt fires when buffered count reaches one, two, three or four.
// R13: Edge events alone may serve as an external interrupt source.
// R14: Up to five independent channels may be instantiated, each self-contained.
// R15: A read returns the oldest value, removes it and updates not-empty.
// R16: A capture into a full buffer sets overflow and is discarded.
package icc_pkg;
    localparam int             ICC_DATA_W   = 32;
    localparam int             ICC_HALF_W   = 16;
    localparam int             ICC_DEPTH    = 4;
    localparam int             ICC_PTR_W    = 2;
    localparam int             ICC_CNT_W    = 3;
    localparam int             ICC_MAX_CHAN = 5;
    localparam logic [3:0]     ICC_PRE_ZERO = 4'h0;
    localparam logic [3:0]     ICC_DIV4_END = 4'h3;
    localparam logic [3:0]     ICC_DIV16_END = 4'hF;
    localparam logic [3:0]     ICC_PRE_ONE  = 4'h1;
    localparam logic [2:0]     ICC_CNT_ZERO = 3'h0;
    localparam logic [2:0]     ICC_CNT_ONE  = 3'h1;
    localparam logic [1:0]     ICC_PTR_ONE  = 2'h1;

    typedef enum logic [2:0] {
        ICC_MODE_OFF     = 3'h0,
        ICC_MODE_FALL    = 3'h1,
        ICC_MODE_RISE    = 3'h2,
        ICC_MODE_BOTH    = 3'h3,
        ICC_MODE_FIRST   = 3'h4,
        ICC_MODE_DIV4    = 3'h5,
        ICC_MODE_DIV16   = 3'h6,
        ICC_MODE_EDGEIRQ = 3'h7
    } icc_mode_t;

    typedef enum logic [1:0] {
        ICC_TB_FIRST  = 2'h0,
        ICC_TB_SECOND = 2'h1,
        ICC_TB_JOINED = 2'h2
    } icc_tb_t;
endpackage : icc_pkg

// [rtl/icc_mem_if.sv]
// Interface between the capture channel and its value store.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface icc_mem_if;
    import icc_pkg::*;
    logic                  wr_en;
    logic [ICC_PTR_W-1:0]  wr_addr;
    logic [ICC_DATA_W-1:0] wr_data;
    logic [ICC_PTR_W-1:0]  rd_addr;
    logic [ICC_DATA_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface : icc_mem_if
`default_nettype wire

// [rtl/icc_mem.sv]
// Four-word store for captured values with a registered read port.
// Assumes the controller never writes and reads the same word in one cycle.
`timescale 1ns/1ps
`default_nettype none
module icc_mem (
    input wire logic clk,
    icc_mem_if.mem   mp
);
    import icc_pkg::*;
    logic [ICC_DATA_W-1:0] words [ICC_DEPTH];
    logic [ICC_DATA_W-1:0] rd_ff;

    always_ff @(posedge clk) begin
        if (mp.wr_en) begin
            words[mp.wr_addr] <= mp.wr_data;
        end
        rd_ff <= words[mp.rd_addr];
    end
    assign mp.rd_data = rd_ff;
endmodule : icc_mem
`default_nettype wire

// [rtl/icc_channel.sv]
// One input capture channel: edge detection, prescaler, four-entry buffer.
// Assumes the pin is asynchronous and the timers share this clock.
`timescale 1ns/1ps
`default_nettype none
module icc_channel (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      capture_input_pin,
    input  wire logic [icc_pkg::ICC_HALF_W-1:0] first_time_base,
    input  wire logic [icc_pkg::ICC_HALF_W-1:0] second_time_base,
    input  wire icc_pkg::icc_mode_t        mode,
    input  wire icc_pkg::icc_tb_t          tb_sel,
    input  wire logic                      first_rising,
    input  wire logic [1:0]                irq_level,
    input  wire logic                      rd_req,
    input  wire logic                      ovf_clr,
    output logic [icc_pkg::ICC_DATA_W-1:0] rd_data_ff,
    output logic                           rd_valid_ff,
    output logic                           not_empty_ff,
    output logic                           overflow_ff,
    output logic [icc_pkg::ICC_CNT_W-1:0]  level_ff,
    output logic                           irq_ff,
    output logic                           wake_ff
);
    import icc_pkg::*;

    // Each channel owns its store and all of its state, so up to ICC_MAX_CHAN copies
    // can sit side by side with nothing shared between them.
    icc_mem_if mbus ();                                                     // R14
    icc_mem u_mem (.clk(clk), .mp(mbus));

    logic                 sync1_ff, sync2_ff, prev_ff;
    logic                 armed_ff, rd_pend_ff;
    logic [3:0]           pre_ff;
    logic [ICC_PTR_W-1:0] wp_ff, rp_ff;
    icc_mode_t            mode_ff;

    // Rising and falling edges of the synchronised pin.
    wire rise_w = sync2_ff & ~prev_ff;
    wire fall_w = ~sync2_ff & prev_ff;
    wire any_w  = rise_w | fall_w;
    wire first_w = first_rising ? rise_w : fall_w;

    // Changing mode restarts the prescaler and the first-edge arming.
    wire mode_chg_w = (mode != mode_ff);

    wire [3:0] pre_end_w = (mode == ICC_MODE_DIV4) ? ICC_DIV4_END : ICC_DIV16_END;
    wire pre_hit_w = rise_w && (pre_ff == pre_end_w);

    logic ev_w;
    always_comb begin
        case (mode)
            ICC_MODE_FALL:    ev_w = fall_w;                        // R2
            ICC_MODE_RISE:    ev_w = rise_w;                        // R3
            ICC_MODE_BOTH:    ev_w = any_w;                         // R4
            ICC_MODE_FIRST:   ev_w = armed_ff ? any_w : first_w;    // R5
            ICC_MODE_DIV4:    ev_w = pre_hit_w;                     // R6
            ICC_MODE_DIV16:   ev_w = pre_hit_w;                     // R7
            ICC_MODE_EDGEIRQ: ev_w = any_w;                         // R13
            default:          ev_w = 1'b0;
        endcase
    end
    wire cap_mode_w = (mode != ICC_MODE_EDGEIRQ);
    wire event_w = ev_w & ~mode_chg_w;

    // Time base selection, zero-extended when one 16-bit timer is chosen.
    wire [ICC_DATA_W-1:0] tb_w =
        (tb_sel == ICC_TB_JOINED) ? {second_time_base, first_time_base} :   // R8
        (tb_sel == ICC_TB_SECOND) ? {{ICC_HALF_W{1'b0}}, second_time_base} :
                                    {{ICC_HALF_W{1'b0}}, first_time_base};

    wire full_w  = (level_ff == ICC_CNT_W'(ICC_DEPTH));
    wire empty_w = (level_ff == ICC_CNT_ZERO);
    wire push_w  = event_w & cap_mode_w & ~full_w;                          // R16
    wire pop_w   = rd_req & ~empty_w;                                       // R15
    wire drop_w  = event_w & cap_mode_w & full_w;                           // R16
    wire [ICC_CNT_W-1:0] nxt_level = level_ff + (push_w ? ICC_CNT_ONE : ICC_CNT_ZERO)
                                              - (pop_w ? ICC_CNT_ONE : ICC_CNT_ZERO);
    wire [ICC_CNT_W-1:0] thr_w = ICC_CNT_W'({1'b0, irq_level}) + ICC_CNT_ONE;
    // Interrupt when buffered count reaches the threshold, or on any edge in edge-only mode.
    wire nxt_irq = cap_mode_w ? (push_w && (nxt_level == thr_w))           // R12
                              : event_w;                                    // R13

    assign mbus.wr_en   = push_w;                                           // R11
    assign mbus.wr_addr = wp_ff;
    assign mbus.wr_data = tb_w;                                             // R1
    assign mbus.rd_addr = rp_ff;

    always_ff @(posedge clk) begin
        sync1_ff <= capture_input_pin;
        sync2_ff <= sync1_ff;
        if (!rst_n) begin
            prev_ff      <= 1'b0;
            mode_ff      <= ICC_MODE_OFF;
            armed_ff     <= 1'b0;
            pre_ff       <= ICC_PRE_ZERO;
            wp_ff        <= '0;
            rp_ff        <= '0;
            level_ff     <= ICC_CNT_ZERO;
            overflow_ff  <= 1'b0;
            irq_ff       <= 1'b0;
            wake_ff      <= 1'b0;
            rd_pend_ff   <= 1'b0;
            rd_valid_ff  <= 1'b0;
            rd_data_ff   <= '0;
            not_empty_ff <= 1'b0;
        end else begin
            prev_ff  <= sync2_ff;
            mode_ff  <= mode;
            armed_ff <= mode_chg_w ? 1'b0 : (armed_ff | (event_w && mode == ICC_MODE_FIRST));
            if (mode_chg_w) begin
                pre_ff <= ICC_PRE_ZERO;
            end else if (rise_w) begin
                pre_ff <= pre_hit_w ? ICC_PRE_ZERO : pre_ff + ICC_PRE_ONE;     // R6 R7
            end
            if (push_w) begin
                wp_ff <= wp_ff + ICC_PTR_ONE;
            end
            if (pop_w) begin
                rp_ff <= rp_ff + ICC_PTR_ONE;                               // R15
            end
            level_ff     <= nxt_level;
            not_empty_ff <= (nxt_level != ICC_CNT_ZERO);                    // R15
            // Set wins over a same-cycle clear.
            overflow_ff  <= drop_w | (overflow_ff & ~ovf_clr);              // R16
            irq_ff       <= nxt_irq;                                        // R10
            wake_ff      <= event_w;                                        // R9
            rd_pend_ff   <= pop_w;
            rd_valid_ff  <= rd_pend_ff;
            if (rd_pend_ff) begin
                rd_data_ff <= mbus.rd_data;
            end
        end
    end

    // Assertions.
    property p_fall;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_FALL && !mode_chg_w && fall_w && !full_w) |-> push_w;
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge not captured"); // R2

    property p_rise_only;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_RISE && push_w) |-> rise_w;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise mode bad capture"); // R3

    property p_both;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_BOTH && !mode_chg_w && any_w) |-> event_w;
    endproperty
    a_both: assert property (p_both) else $error("edge missed in both mode"); // R4

    property p_div4;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_DIV4 && event_w) |-> (pre_ff == ICC_DIV4_END);
    endproperty
    a_div4: assert property (p_div4) else $error("div4 capture off count"); // R6

    property p_div16;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_DIV16 && event_w) |-> (pre_ff == ICC_DIV16_END);
    endproperty
    a_div16: assert property (p_div16) else $error("div16 capture off count"); // R7

    property p_full;
        @(posedge clk) disable iff (!rst_n)
        level_ff <= ICC_CNT_W'(ICC_DEPTH);
    endproperty
    a_full: assert property (p_full) else $error("buffer level above depth"); // R11

    property p_ovf;
        @(posedge clk) disable iff (!rst_n)
        drop_w |=> (overflow_ff &&
                    level_ff == ($past(pop_w) ? ICC_CNT_W'(ICC_DEPTH) - ICC_CNT_ONE
                                              : ICC_CNT_W'(ICC_DEPTH)));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // R16

    property p_read;
        @(posedge clk) disable iff (!rst_n)
        pop_w |-> ##2 rd_valid_ff;
    endproperty
    a_read: assert property (p_read) else $error("read data not returned"); // R15

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
        (cap_mode_w && push_w && nxt_level == thr_w) |=> irq_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("threshold interrupt missed"); // R12

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        event_w |=> wake_ff;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not raised"); // R9

    // A capture interrupt must leave the level exactly at the threshold chosen then.
    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        (irq_ff && $past(cap_mode_w)) |-> (level_ff == $past(thr_w));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt at wrong level"); // R12

    property p_irq_cause;
        @(posedge clk) disable iff (!rst_n)
        irq_ff |-> $past(event_w);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event"); // R10

    property p_first_arm;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_FIRST && !armed_ff && push_w) |-> first_w;
    endproperty
    a_first_arm: assert property (p_first_arm) else $error("capture before first edge"); // R5

    property p_div4_range;
        @(posedge clk) disable iff (!rst_n)
        (mode == ICC_MODE_DIV4 && !mode_chg_w) |-> (pre_ff <= ICC_DIV4_END);
    endproperty
    a_div4_range: assert property (p_div4_range) else $error("div4 count out of range"); // R6

    c_full: cover property (@(posedge clk) disable iff (!rst_n) full_w);
    c_drop: cover property (@(posedge clk) disable iff (!rst_n) drop_w);
    c_div16: cover property (@(posedge clk) disable iff (!rst_n)
        mode == ICC_MODE_DIV16 && event_w);
    c_read: cover property (@(posedge clk) disable iff (!rst_n) rd_valid_ff);
    c_first: cover property (@(posedge clk) disable iff (!rst_n)
        mode == ICC_MODE_FIRST && !armed_ff && push_w);
endmodule : icc_channel
`default_nettype wire

// [test/icc_pin_drv.sv]
// Stand-in for the external signal that drives the capture pin.
// Assumes the caller enters put just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module icc_pin_drv (
    input  wire logic clk,
    output var logic  pin
);
    initial pin = 1'b0;
    // The level is held for several cycles, because the pin is synchronised
    // by two flops and the capture lands some cycles after the change.
    task automatic put(input logic v, input int hold);
        @(posedge clk) #1 pin = v;
        repeat (hold) @(posedge clk);
        #1;
    endtask : put
endmodule : icc_pin_drv
`default_nettype wire

// [test/input_capture_channel_tb.sv]
// Self-checking bench for one input capture channel.
// Assumes icc_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel_tb;
    import icc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd_req = 1'b0, ovf_clr = 1'b0, first_rising = 1'b0;
    logic [15:0] tb1 = 16'h0, tb2 = 16'h0;
    logic [1:0] irq_level = 2'h0;
    icc_mode_t mode = ICC_MODE_OFF;
    icc_tb_t sel = ICC_TB_FIRST;
    wire pin;
    logic [31:0] rd_data_ff;
    logic [2:0] level_ff;
    logic rd_valid_ff, not_empty_ff, overflow_ff, irq_ff, wake_ff;
    int err_total = 0, n_tests = 0, irqs = 0, wakes = 0, cyc_n = 0;

    icc_pin_drv drv (.clk(clk), .pin(pin));
    icc_channel dut (.clk(clk), .rst_n(rst_n), .capture_input_pin(pin),
        .first_time_base(tb1), .second_time_base(tb2), .mode(mode), .tb_sel(sel),
        .first_rising(first_rising), .irq_level(irq_level), .rd_req(rd_req),
        .ovf_clr(ovf_clr), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .not_empty_ff(not_empty_ff), .overflow_ff(overflow_ff), .level_ff(level_ff),
        .irq_ff(irq_ff), .wake_ff(wake_ff));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (irq_ff === 1'b1) irqs++;
        if (wake_ff === 1'b1) wakes++;
        cyc_n++;
        if (cyc_n == 8000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    // Every scenario starts from reset so prescaler and arming begin afresh.
    task automatic restart(input icc_mode_t m, input icc_tb_t s, input logic [1:0] l);
        @(posedge clk) #1 rst_n = 1'b0;
        mode = m;
        sel = s;
        irq_level = l;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 irqs = 0;
        wakes = 0;
    endtask : restart
    task automatic ev(input logic v, input logic [15:0] a, input logic [15:0] b);
        tb1 = a;
        tb2 = b;
        drv.put(v, 6);
    endtask : ev
    task automatic rd();
        int n;
        n = 0;
        rd_req = 1'b1;
        @(posedge clk) #1 rd_req = 1'b0;
        while (rd_valid_ff !== 1'b1 && n < 4) begin
            @(posedge clk) #1;
            n++;
        end
        chk(rd_valid_ff, 32'h1);
    endtask : rd

    task automatic t_rise();
        restart(ICC_MODE_RISE, ICC_TB_FIRST, 2'h0);
        ev(1'b1, 16'h1111, 16'h2222);
        ev(1'b0, 16'h3333, 16'h4444);
        chk(level_ff, 32'h1);
        chk(wakes, 32'h1);
        chk(irqs, 32'h1);
        rd();
        chk(rd_data_ff, 32'h1111);
        chk(not_empty_ff, 32'h0);
    endtask : t_rise
    task automatic t_fall();
        restart(ICC_MODE_FALL, ICC_TB_SECOND, 2'h0);
        ev(1'b1, 16'h0101, 16'h0202);
        ev(1'b0, 16'h0303, 16'h0404);
        chk(level_ff, 32'h1);
        rd();
        chk(rd_data_ff, 32'h0404);
    endtask : t_fall
    task automatic t_both();
        restart(ICC_MODE_BOTH, ICC_TB_JOINED, 2'h1);
        ev(1'b1, 16'hAAAA, 16'h5555);
        chk(irqs, 32'h0);
        ev(1'b0, 16'h1234, 16'h5678);
        chk(irqs, 32'h1);
        rd();
        chk(rd_data_ff, 32'h5555AAAA);
        rd();
        chk(rd_data_ff, 32'h56781234);
    endtask : t_both
    task automatic t_first();
        first_rising = 1'b0;
        restart(ICC_MODE_FIRST, ICC_TB_FIRST, 2'h0);
        ev(1'b1, 16'h0011, 16'h0);
        ev(1'b0, 16'h0022, 16'h0);
        ev(1'b1, 16'h0033, 16'h0);
        chk(level_ff, 32'h2);
        rd();
        chk(rd_data_ff, 32'h0022);
        ev(1'b0, 16'h0044, 16'h0);
        ev(1'b1, 16'h0055, 16'h0);
        // Rising first: the pin stays high through reset, so the first edge seen is a fall.
        first_rising = 1'b1;
        restart(ICC_MODE_FIRST, ICC_TB_FIRST, 2'h0);
        ev(1'b0, 16'h0066, 16'h0);
        ev(1'b1, 16'h0077, 16'h0);
        ev(1'b0, 16'h0088, 16'h0);
        chk(level_ff, 32'h2);
        rd();
        chk(rd_data_ff, 32'h0077);
    endtask : t_first
    task automatic t_div(input icc_mode_t m, input int n);
        restart(m, ICC_TB_FIRST, 2'h0);
        for (int i = 1; i <= 2 * n; i++) begin
            ev(1'b1, 16'(i), 16'h0);
            ev(1'b0, 16'h0, 16'h0);
        end
        chk(level_ff, 32'h2);
        rd();
        chk(rd_data_ff, 32'(n));
        rd();
        chk(rd_data_ff, 32'(2 * n));
    endtask : t_div
    task automatic t_full();
        restart(ICC_MODE_RISE, ICC_TB_FIRST, 2'h3);
        for (int i = 1; i <= 5; i++) begin
            ev(1'b1, 16'(i), 16'h0);
            ev(1'b0, 16'h0, 16'h0);
        end
        chk(level_ff, 32'h4);
        chk(overflow_ff, 32'h1);
        chk(irqs, 32'h1);
        for (int i = 1; i <= 4; i++) begin
            rd();
            chk(rd_data_ff, 32'(i));
        end
        chk(not_empty_ff, 32'h0);
        ovf_clr = 1'b1;
        @(posedge clk) #1 ovf_clr = 1'b0;
        @(posedge clk) #1 chk(overflow_ff, 32'h0);
    endtask : t_full
    task automatic t_edge();
        restart(ICC_MODE_EDGEIRQ, ICC_TB_FIRST, 2'h0);
        ev(1'b1, 16'h0, 16'h0);
        ev(1'b0, 16'h0, 16'h0);
        chk(irqs, 32'h2);
        chk(wakes, 32'h2);
        chk(level_ff, 32'h0);
        restart(ICC_MODE_OFF, ICC_TB_FIRST, 2'h0);
        ev(1'b1, 16'h0, 16'h0);
        ev(1'b0, 16'h0, 16'h0);
        chk(wakes, 32'h0);
    endtask : t_edge

    initial begin
        t_rise();
        t_fall();
        t_both();
        t_first();
        t_div(ICC_MODE_DIV4, 4);
        t_div(ICC_MODE_DIV16, 16);
        t_full();
        t_edge();
        end_of_test();
    end
endmodule : input_capture_channel_tb
`default_nettype wire
